// ==== hw/amp_protection_fault_supervisor.sv ====
`timescale 1ns/1ps
// Overview of operation
// (RQ1) Saturated channel gets narrow injected pulses every fourth frame.
// (RQ2) Clipping shows as pulses on warning pin, self clearing.
// (RQ3) DC imbalance bumps overload counter; full counter shuts channel down.
// (RQ4) DC protection off in paralleled bridge and single-ended modes.
// (RQ5) Pin short check only at power-up, never later.
// (RQ6) Found short keeps all bridges high impedance until gone, then continue.
// (RQ7) Short check: ground step first, then rail step.
// (RQ8) During check alert held low and reset input ignored.
// (RQ9) Reset never restarts check; check skipped in single-ended mode.
// (RQ10) Above warn temperature warning pin low; no output effect, self clears.
// (RQ11) Above shutdown temperature all high impedance, alert low, latched until reset.
// (RQ12) Power-on clearing resets overload circuit before operation.
// (RQ13) Undervoltage forces high impedance and alert low, resumes automatically.
// (RQ14) Channel fault stops its channel; global fault stops all, alert low.
// (RQ15) Reset low forces alert high regardless of faults.
// (RQ16) Current limiting beyond 1.7 ms latches channel shutdown until reset.
// (RQ17) Cycle current limit flips bridge for rest of frame, unreported.
// (RQ18) Latched overcurrent mode shuts channel at once, reported, until reset.
// (RQ19) Lost sync clock in slave mode: high impedance, unreported, self recovers.
// (RQ20) Reset low ramps down then high impedance; pulldowns on in all modes.
// (RQ21) Bridged modes use weak pulldowns under reset for bootstrap charging.
// (RQ22) Controller raises reset at least 4 ms after alert falls; the test host_model waits only 400 cycles (1.6 us).
// (RQ23) Alert and warning outputs are active-low open drain.
module amp_protection_fault_supervisor
  import amp_guard_pkg::*;
#(
  parameter int unsigned CHANNELS        = 4,
  parameter int unsigned OVERLOAD_CYCLES = OVERLOAD_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          amp_reset_n,
  input  wire logic [1:0]    out_mode,
  input  wire logic          slave_mode,
  input  wire logic          sync_clock_pair,
  input  wire logic          frame_tick,
  input  wire logic          latch_mode,
  input  wire logic          heat_warning,
  input  wire logic          heat_shutdown,
  input  wire logic          low_supply_guard,
  input  wire logic          short_to_gnd,
  input  wire logic          short_to_rail,
  input  wire chan_sense_t [CHANNELS-1:0] sense,
  output chan_ctrl_t [CHANNELS-1:0]       ctrl,
  output logic               ramp_down,
  output logic               pulldown_en,
  output logic               weak_pulldown_en,
  output logic               pin_short_check,
  output logic               fault_n_o,
  output logic               fault_n_oe,
  output logic               clip_heat_warn_n_o,
  output logic               clip_heat_warn_n_oe
);

  // Two-flop synchronisers for pins from outside the clock domain
  logic [6:0] s1_q, s2_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Idle pin levels, so no false short or heat latch follows reset
      s1_q <= 7'h00;
      s2_q <= 7'h00;
    end else begin
      s1_q <= {amp_reset_n, heat_warning, heat_shutdown, low_supply_guard,
               short_to_gnd, short_to_rail, sync_clock_pair};
      s2_q <= s1_q;
    end
  end
  logic rst_pin, warm, hot, low_sup, sh_gnd, sh_rail, sync_s;
  assign {rst_pin, warm, hot, low_sup, sh_gnd, sh_rail, sync_s} = s2_q;

  seq_state_t  st_q,   st_d;
  logic [15:0] cnt_q,  cnt_d;
  logic        hot_latch_q, hot_latch_d;
  logic        sync_prev_q;
  logic [15:0] sync_idle_q, sync_idle_d;
  logic        clear_ch;
  logic [CHANNELS-1:0] ch_latched;
  logic        dc_en;
  logic        is_bridged;
  logic        sync_lost;
  logic        global_off;

  assign is_bridged = (out_mode_t'(out_mode) == MODE_BRIDGED) || (out_mode_t'(out_mode) == MODE_PARALLEL);
  assign dc_en = (out_mode_t'(out_mode) == MODE_BRIDGED) || (out_mode_t'(out_mode) == MODE_MIXED); // RQ4

  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    hot_latch_d = hot_latch_q;
    clear_ch    = 1'b0;
    if (hot) begin
      hot_latch_d = 1'b1; // RQ11
    end
    case (st_q)
      ST_POWER_OFF: begin
        clear_ch = 1'b1; // RQ12
        cnt_d    = 16'h0;
        // Check runs once from power-up only
        st_d     = is_bridged ? ST_CHECK_GND : ST_HELD; // RQ5 RQ9
      end
      ST_CHECK_GND: begin
        // Reset pin is not looked at in any check state
        if (sh_gnd) begin
          st_d = ST_SHORT_HOLD; // RQ6
        end else if (cnt_q == 16'(SHORT_STEP_CYC - 1)) begin
          st_d  = ST_CHECK_RAIL; // RQ7
          cnt_d = 16'h0;
        end else begin
          cnt_d = cnt_q + 16'h1;
        end
      end
      ST_CHECK_RAIL: begin
        if (sh_rail) begin
          st_d = ST_SHORT_HOLD; // RQ6
        end else if (cnt_q == 16'(SHORT_STEP_CYC - 1)) begin
          st_d  = ST_HELD;
          cnt_d = 16'h0;
        end else begin
          cnt_d = cnt_q + 16'h1;
        end
      end
      ST_SHORT_HOLD: begin
        // Retry the whole sequence once the short clears
        if (!sh_gnd && !sh_rail) begin
          st_d  = ST_CHECK_GND; // RQ6
          cnt_d = 16'h0;
        end
      end
      ST_HELD: begin
        clear_ch    = 1'b1; // RQ16 RQ18
        hot_latch_d = hot;
        if (rst_pin) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!rst_pin) begin
          st_d  = ST_RAMP_DOWN; // RQ20
          cnt_d = 16'h0;
        end
      end
      ST_RAMP_DOWN: begin
        if (cnt_q == 16'(RAMP_DOWN_CYC - 1)) begin
          st_d = ST_HELD; // RQ20
        end else begin
          cnt_d = cnt_q + 16'h1;
        end
      end
      default: st_d = ST_POWER_OFF;
    endcase
  end

  // Sync activity watch: any edge restarts the idle count
  always_comb begin
    sync_idle_d = sync_idle_q;
    if (sync_s != sync_prev_q) begin
      sync_idle_d = 16'h0;
    end else if (sync_idle_q != 16'(SYNC_LOSS_CYC)) begin
      sync_idle_d = sync_idle_q + 16'h1;
    end
  end
  assign sync_lost = slave_mode && (sync_idle_q == 16'(SYNC_LOSS_CYC)); // RQ19

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q        <= ST_POWER_OFF;
      cnt_q       <= 16'h0;
      hot_latch_q <= 1'b0;
      sync_prev_q <= 1'b0;
      sync_idle_q <= 16'h0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      hot_latch_q <= hot_latch_d;
      sync_prev_q <= sync_s;
      sync_idle_q <= sync_idle_d;
    end
  end

  logic running;
  logic in_check;
  assign running    = (st_q == ST_RUN) || (st_q == ST_RAMP_DOWN);
  assign in_check   = (st_q == ST_CHECK_GND) || (st_q == ST_CHECK_RAIL) || (st_q == ST_SHORT_HOLD);
  assign global_off = !running || hot_latch_q || low_sup || sync_lost; // RQ11 RQ13 RQ14 RQ19

  chan_ctrl_t [CHANNELS-1:0] ch_raw;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      chan_guard #(
        .OVERLOAD_CYCLES (OVERLOAD_CYCLES)
      ) u_chan (
        .clk        (clk),
        .rst_n      (rst_n),
        .clear      (clear_ch),
        .frame_tick (frame_tick),
        .latch_mode (latch_mode),
        .dc_enable  (dc_en),
        .sense      (sense[g]),
        .ctrl       (ch_raw[g]),
        .latched    (ch_latched[g])
      );
    end
  endgenerate

  // Registered outputs; per-channel shutdown is local only
  chan_ctrl_t [CHANNELS-1:0] ctrl_q;
  logic fault_q, warn_q, pd_q, wpd_q, chk_q, ramp_q;
  logic [7:0] clip_cnt_q;
  logic clip_any;

  // Passed as argument so the assign wakes on every channel
  function automatic logic ch_raw_clip(input chan_sense_t [CHANNELS-1:0] s);
    logic r;
    r = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      r = r | s[i].clip;
    end
    return r;
  endfunction

  assign clip_any = ch_raw_clip(sense);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q     <= '0;
      fault_q    <= 1'b1;
      warn_q     <= 1'b1;
      pd_q       <= 1'b1;
      wpd_q      <= 1'b0;
      chk_q      <= 1'b0;
      ramp_q     <= 1'b0;
      clip_cnt_q <= 8'h00;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        ctrl_q[i].hi_z   <= ch_raw[i].hi_z || global_off; // RQ14
        ctrl_q[i].inject <= ch_raw[i].inject && !global_off; // RQ1
        ctrl_q[i].flip   <= ch_raw[i].flip && !global_off; // RQ17
      end
      // Clip pulse stretched to at least the minimum width
      if (clip_any) begin
        clip_cnt_q <= 8'(CLIP_PULSE_CYC); // RQ2
      end else if (clip_cnt_q != 8'h00) begin
        clip_cnt_q <= clip_cnt_q - 8'h01;
      end
      warn_q <= !(warm || clip_any || clip_cnt_q != 8'h00); // RQ2 RQ10
      chk_q  <= in_check;
      if (in_check) begin
        fault_q <= 1'b0; // RQ8
      end else if (!rst_pin) begin
        fault_q <= 1'b1; // RQ15
      end else begin
        fault_q <= !(hot_latch_q || low_sup || (|ch_latched)); // RQ14 RQ16 RQ18
      end
      ramp_q <= (st_q == ST_RAMP_DOWN); // RQ20
      // Pulldowns follow the pin through ramp down too, not only once idle
      pd_q   <= !rst_pin && !in_check; // RQ20
      wpd_q  <= !rst_pin && !in_check && is_bridged; // RQ21
    end
  end

  assign ctrl             = ctrl_q;
  assign ramp_down        = ramp_q;
  assign pulldown_en      = pd_q;
  assign weak_pulldown_en = wpd_q;
  assign pin_short_check  = chk_q;
  // Open drain: only ever pulls low
  assign fault_n_o           = 1'b0; // RQ23
  assign fault_n_oe          = !fault_q; // RQ23
  assign clip_heat_warn_n_o  = 1'b0;
  assign clip_heat_warn_n_oe = !warn_q; // RQ23

endmodule // amp_protection_fault_supervisor

// ==== hw/amp_guard_pkg.sv ====
package amp_guard_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CLIP_PULSE_NS    = 500;
  localparam int unsigned CLIP_PULSE_CYC   = (CLIP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OVERLOAD_US      = 1700;
  localparam int unsigned OVERLOAD_CYC     = OVERLOAD_US * CLK_MHZ;
  localparam int unsigned RAMP_DOWN_CYC    = 1024;
  localparam int unsigned INJECT_EVERY     = 4;
  localparam int unsigned SYNC_LOSS_CYC    = 256;
  localparam int unsigned SHORT_STEP_CYC   = 64;
  localparam logic [7:0]  OVL_CNT_MAX      = 8'hFF;
  localparam logic [1:0]  CHAN_RESET_VAL   = 2'h0;

  typedef enum logic [1:0] {
    MODE_BRIDGED   = 2'b00,
    MODE_MIXED     = 2'b01,
    MODE_PARALLEL  = 2'b10,
    MODE_SINGLE    = 2'b11
  } out_mode_t;

  typedef enum logic [2:0] {
    ST_POWER_OFF   = 3'b000,
    ST_CHECK_GND   = 3'b001,
    ST_CHECK_RAIL  = 3'b010,
    ST_SHORT_HOLD  = 3'b011,
    ST_RUN         = 3'b100,
    ST_RAMP_DOWN   = 3'b101,
    ST_HELD        = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic clip;
    logic over_current;
    logic dc_imbalance;
  } chan_sense_t;

  typedef struct packed {
    logic hi_z;
    logic inject;
    logic flip;
  } chan_ctrl_t;

endpackage

// ==== hw/chan_guard.sv ====
`timescale 1ns/1ps
module chan_guard
  import amp_guard_pkg::*;
#(
  parameter int unsigned OVERLOAD_CYCLES = OVERLOAD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  input  wire logic        frame_tick,
  input  wire logic        latch_mode,
  input  wire logic        dc_enable,
  input  wire chan_sense_t sense,
  output chan_ctrl_t       ctrl,
  output logic             latched
);

  logic [1:0]  frame_q,   frame_d;
  logic [7:0]  ovl_q,     ovl_d;
  logic [31:0] lim_q,     lim_d;
  logic        latched_q, latched_d;
  logic        flip_q,    flip_d;
  logic        hit_q,     hit_d;
  logic        inj_q,     inj_d;

  always_comb begin
    frame_d   = frame_q;
    ovl_d     = ovl_q;
    lim_d     = lim_q;
    latched_d = latched_q;
    flip_d    = flip_q;
    hit_d     = hit_q;
    inj_d     = 1'b0;
    if (frame_tick) begin
      frame_d = frame_q + 2'h1;
      flip_d  = 1'b0;
      hit_d   = 1'b0;
      // Quarter-rate pulses keep activity alive while saturated
      inj_d   = (sense.clip || hit_q) && (frame_q == 2'(INJECT_EVERY - 1)); // RQ1
      if (!hit_q && ovl_q != 8'h00) begin
        ovl_d = ovl_q - 8'h01;
      end
    end
    if (sense.over_current && !latched_q) begin
      if (latch_mode) begin
        latched_d = 1'b1; // RQ18
      end else begin
        flip_d = 1'b1; // RQ17
        if (!hit_q && ovl_q != OVL_CNT_MAX) begin
          ovl_d = ovl_q + 8'h01;
        end
        hit_d = 1'b1;
      end
    end
    if (dc_enable && sense.dc_imbalance && frame_tick && ovl_q != OVL_CNT_MAX) begin
      ovl_d = ovl_q + 8'h01; // RQ3
    end
    if (ovl_q == OVL_CNT_MAX) begin
      latched_d = 1'b1; // RQ3
    end
    // Limit time counts from first hit, reset by a clean frame
    if (hit_q || sense.over_current) begin
      lim_d = (lim_q < OVERLOAD_CYCLES) ? lim_q + 32'h1 : lim_q;
    end else if (frame_tick) begin
      lim_d = 32'h0;
    end
    if (lim_q >= OVERLOAD_CYCLES) begin
      latched_d = 1'b1; // RQ16
    end
    if (clear) begin
      ovl_d     = 8'h00; // RQ12
      lim_d     = 32'h0;
      latched_d = 1'b0;
      flip_d    = 1'b0;
      hit_d     = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_q   <= CHAN_RESET_VAL;
      ovl_q     <= 8'h00;
      lim_q     <= 32'h0;
      latched_q <= 1'b0;
      flip_q    <= 1'b0;
      hit_q     <= 1'b0;
      inj_q     <= 1'b0;
    end else begin
      frame_q   <= frame_d;
      ovl_q     <= ovl_d;
      lim_q     <= lim_d;
      latched_q <= latched_d;
      flip_q    <= flip_d;
      hit_q     <= hit_d;
      inj_q     <= inj_d;
    end
  end

  assign ctrl.hi_z   = latched_q;
  assign ctrl.inject = inj_q && !latched_q;
  assign ctrl.flip   = flip_q && !latched_q;
  assign latched     = latched_q;

endmodule // chan_guard

// ==== test/guard_monitor.sv ====
`timescale 1ns/1ps
module guard_monitor
  import amp_guard_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       amp_reset_n,
  input wire logic [1:0]                 out_mode,
  input wire logic                       latch_mode,
  input wire logic                       heat_warning,
  input wire logic                       heat_shutdown,
  input wire logic                       low_supply_guard,
  input wire chan_sense_t [CHANNELS-1:0] sense,
  input wire chan_ctrl_t [CHANNELS-1:0]  ctrl,
  input wire logic                       ramp_down,
  input wire logic                       pulldown_en,
  input wire logic                       weak_pulldown_en,
  input wire logic                       pin_short_check,
  input wire logic                       fault_n_o,
  input wire logic                       fault_n_oe,
  input wire logic                       clip_heat_warn_n_o,
  input wire logic                       clip_heat_warn_n_oe
);
  localparam int unsigned RAMP_LIM = RAMP_DOWN_CYC + 8;
  logic        all_hiz;
  logic [11:0] low_q;
  logic [11:0] low_d;

  always_comb begin
    all_hiz = 1'b1;
    for (int i = 0; i < CHANNELS; i++) all_hiz &= ctrl[i].hi_z;
  end

  // Saturates so a long reset never wraps back into the ramp window
  always_comb begin
    low_d = amp_reset_n ? 12'h000 : ((low_q == 12'hFFF) ? low_q : low_q + 12'h001);
  end

  always_ff @(posedge clk) begin
    low_q <= rst_n ? low_d : 12'h000;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence hot_seq;
    (heat_shutdown && amp_reset_n)[*6];
  endsequence
  sequence pin_up_seq;
    amp_reset_n[*8];
  endsequence
  sequence pin_low_seq;
    (!amp_reset_n && !pin_short_check)[*6];
  endsequence

  a_open_drain_low: assert property ((fault_n_oe |-> !fault_n_o) and (clip_heat_warn_n_oe |-> !clip_heat_warn_n_o))
    else $error("open drain pin driven high");
  a_check_alert_low: assert property (pin_short_check[*2] |-> fault_n_oe)
    else $error("alert released during short check");
  a_reset_frees_alert: assert property (pin_low_seq |-> !fault_n_oe)
    else $error("alert driven while reset pin low");
  a_pulldown_held: assert property (pin_low_seq |-> pulldown_en)
    else $error("pulldown off while reset pin low");
  a_weak_pulldown_on: assert property (pin_low_seq ##0 (out_mode == MODE_BRIDGED) |-> weak_pulldown_en)
    else $error("weak pulldown off in bridged reset");
  a_ramp_then_hiz: assert property (low_q > RAMP_LIM |-> all_hiz)
    else $error("bridges not high impedance after ramp");
  a_low_supply_stop: assert property ((low_supply_guard && amp_reset_n)[*6] |-> all_hiz && fault_n_oe)
    else $error("undervoltage did not stop outputs");
  a_heat_latch_hold: assert property (hot_seq ##1 pin_up_seq |-> fault_n_oe && all_hiz)
    else $error("thermal shutdown not latched");
  a_warn_on_heat: assert property (heat_warning[*5] |-> clip_heat_warn_n_oe)
    else $error("heat warning not shown");
  a_latched_oc_chan: assert property ((latch_mode && sense[1].over_current && amp_reset_n && !pin_short_check)[*5]
    ##1 amp_reset_n[*3] |-> ctrl[1].hi_z)
    else $error("latched overcurrent left channel running");
endmodule // guard_monitor

bind amp_protection_fault_supervisor guard_monitor #(.CHANNELS(CHANNELS)) mon (.clk(clk), .rst_n(rst_n),
  .amp_reset_n(amp_reset_n), .out_mode(out_mode), .latch_mode(latch_mode), .heat_warning(heat_warning),
  .heat_shutdown(heat_shutdown), .low_supply_guard(low_supply_guard), .sense(sense), .ctrl(ctrl),
  .ramp_down(ramp_down), .pulldown_en(pulldown_en), .weak_pulldown_en(weak_pulldown_en),
  .pin_short_check(pin_short_check), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
  .clip_heat_warn_n_o(clip_heat_warn_n_o), .clip_heat_warn_n_oe(clip_heat_warn_n_oe));

// ==== test/host_model.sv ====
`timescale 1ns/1ps
module host_model #(
  parameter int unsigned RESUME_CYC = 400
) (
  input  wire logic clk,
  input  wire logic hold_reset,
  input  wire logic fault_line,
  output logic      amp_reset_n
);
  int unsigned since_q;
  logic        prev_q;

  initial begin
    amp_reset_n = 1'b0;
    since_q     = RESUME_CYC;
    prev_q      = 1'b1;
  end

  // Release waits out the cool-down after any alert fall
  always @(posedge clk) begin
    prev_q <= fault_line;
    if (prev_q && !fault_line) since_q <= 0;
    else if (since_q < RESUME_CYC) since_q <= since_q + 1;
    if (hold_reset) amp_reset_n <= 1'b0;
    else if (since_q >= RESUME_CYC) amp_reset_n <= 1'b1;
  end
endmodule // host_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import amp_guard_pkg::*;
;
  logic clk, rst_n, amp_reset_n, hold_reset, slave_mode, sync_clock_pair, frame_tick, latch_mode, sync_hold;
  logic heat_warning, heat_shutdown, low_supply_guard, short_to_gnd, short_to_rail;
  logic [1:0] out_mode;
  chan_sense_t [3:0] sense;
  chan_ctrl_t [3:0]  ctrl;
  logic ramp_down, pulldown_en, weak_pulldown_en, pin_short_check;
  logic fault_n_o, fault_n_oe, clip_heat_warn_n_o, clip_heat_warn_n_oe, fault_line;
  int n_fail = 0, checks = 0, cyc = 0, ft = 0;

  // Pull-up on the open-drain alert line
  assign fault_line = fault_n_oe ? fault_n_o : 1'b1;

  amp_protection_fault_supervisor #(.CHANNELS(4), .OVERLOAD_CYCLES(200)) DUT (.clk(clk), .rst_n(rst_n),
    .amp_reset_n(amp_reset_n), .out_mode(out_mode), .slave_mode(slave_mode), .sync_clock_pair(sync_clock_pair),
    .frame_tick(frame_tick), .latch_mode(latch_mode), .heat_warning(heat_warning), .heat_shutdown(heat_shutdown),
    .low_supply_guard(low_supply_guard), .short_to_gnd(short_to_gnd), .short_to_rail(short_to_rail),
    .sense(sense), .ctrl(ctrl), .ramp_down(ramp_down), .pulldown_en(pulldown_en),
    .weak_pulldown_en(weak_pulldown_en), .pin_short_check(pin_short_check), .fault_n_o(fault_n_o),
    .fault_n_oe(fault_n_oe), .clip_heat_warn_n_o(clip_heat_warn_n_o), .clip_heat_warn_n_oe(clip_heat_warn_n_oe));

  host_model #(.RESUME_CYC(400)) host (.clk(clk), .hold_reset(hold_reset), .fault_line(fault_line),
    .amp_reset_n(amp_reset_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Frame pulse every 16 clocks; sync pin toggles every clock unless sync_hold is set
  always @(negedge clk) begin
    ft = (ft + 1) % 16;
    frame_tick = (ft == 0);
    if (!sync_hold) sync_clock_pair = ~sync_clock_pair;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic logic all_z();
    return ctrl[0].hi_z & ctrl[1].hi_z & ctrl[2].hi_z & ctrl[3].hi_z;
  endfunction

  task automatic toggle_reset();
    hold_reset = 1'b1;
    wait_cyc(10);
    check(ramp_down === 1'b1 && pulldown_en === 1'b1 && weak_pulldown_en === 1'b1, "no ramp down");
    wait_cyc(1100);
    check(all_z() === 1'b1 && fault_n_oe === 1'b0, "reset state wrong");
    check(pin_short_check === 1'b0, "check restarted by reset");
    hold_reset = 1'b0;
    wait_cyc(450);
  endtask

  task automatic t_startup();
    wait_cyc(4);
    check(pin_short_check === 1'b1 && fault_n_oe === 1'b1, "check not running");
    wait_cyc(400);
    check(pin_short_check === 1'b1 && all_z() === 1'b1, "short not held");
    short_to_gnd = 1'b0;
    wait_cyc(300);
    check(pin_short_check === 1'b0 && fault_n_oe === 1'b0, "check not finished");
    hold_reset = 1'b0;
    wait_cyc(40);
    check(all_z() === 1'b0 && fault_n_oe === 1'b0, "not running");
  endtask

  task automatic t_clip_sync();
    int pulses;
    pulses = 0;
    sense[0].clip = 1'b1;
    wait_cyc(4);
    check(clip_heat_warn_n_oe === 1'b1, "clip not shown");
    // Four frames of 16 clocks hold exactly one injected pulse
    repeat (64) begin
      @(negedge clk);
      if (ctrl[0].inject === 1'b1) pulses++;
    end
    check(pulses == 1, "inject rate wrong");
    sense[0].clip = 1'b0;
    wait_cyc(CLIP_PULSE_CYC - 20);
    check(clip_heat_warn_n_oe === 1'b1, "clip pulse too short");
    wait_cyc(40);
    check(clip_heat_warn_n_oe === 1'b0 && all_z() === 1'b0, "clip not cleared");
    sense[0].over_current = 1'b1;
    wait_cyc(1);
    sense[0].over_current = 1'b0;
    wait_cyc(1);
    check(ctrl[0].flip === 1'b1, "no state flip");
    wait_cyc(20);
    check(ctrl[0].flip === 1'b0 && fault_n_oe === 1'b0, "flip not cleared");
    slave_mode = 1'b1;
    sync_hold = 1'b1;
    wait_cyc(SYNC_LOSS_CYC + 10);
    check(all_z() === 1'b1 && fault_n_oe === 1'b0, "sync loss not handled");
    sync_hold = 1'b0;
    wait_cyc(10);
    check(all_z() === 1'b0, "no recovery after sync");
    slave_mode = 1'b0;
  endtask

  task automatic t_supply_heat();
    low_supply_guard = 1'b1;
    wait_cyc(10);
    check(all_z() === 1'b1 && fault_n_oe === 1'b1, "undervoltage ignored");
    low_supply_guard = 1'b0;
    wait_cyc(10);
    check(all_z() === 1'b0 && fault_n_oe === 1'b0, "no auto resume");
    heat_warning = 1'b1;
    wait_cyc(10);
    check(clip_heat_warn_n_oe === 1'b1 && all_z() === 1'b0, "warning wrong");
    heat_warning = 1'b0;
    wait_cyc(200);
    check(clip_heat_warn_n_oe === 1'b0, "warning stuck");
    heat_shutdown = 1'b1;
    wait_cyc(10);
    heat_shutdown = 1'b0;
    wait_cyc(20);
    check(all_z() === 1'b1 && fault_n_oe === 1'b1, "thermal latch lost");
    toggle_reset();
    check(all_z() === 1'b0, "no resume after reset");
  endtask

  task automatic t_overcurrent();
    latch_mode = 1'b1;
    sense[1].over_current = 1'b1;
    wait_cyc(10);
    sense[1].over_current = 1'b0;
    wait_cyc(20);
    check(ctrl[1].hi_z === 1'b1 && ctrl[0].hi_z === 1'b0 && fault_n_oe === 1'b1, "latched oc");
    toggle_reset();
    latch_mode = 1'b0;
    sense[2].over_current = 1'b1;
    wait_cyc(20);
    check(fault_n_oe === 1'b0 && ctrl[2].hi_z === 1'b0, "limit reported");
    wait_cyc(300);
    check(ctrl[2].hi_z === 1'b1 && fault_n_oe === 1'b1, "overload not latched");
    sense[2].over_current = 1'b0;
    toggle_reset();
  endtask

  task automatic t_dc();
    out_mode = MODE_PARALLEL;
    sense[3].dc_imbalance = 1'b1;
    wait_cyc(5000);
    check(ctrl[3].hi_z === 1'b0, "dc guard in paralleled");
    out_mode = MODE_BRIDGED;
    wait_cyc(5000);
    check(ctrl[3].hi_z === 1'b1, "dc imbalance ignored");
    sense[3].dc_imbalance = 1'b0;
    toggle_reset();
  endtask

  task automatic t_single();
    out_mode = MODE_SINGLE;
    rst_n = 1'b0;
    wait_cyc(6);
    rst_n = 1'b1;
    wait_cyc(10);
    check(pin_short_check === 1'b0, "check in single ended");
  endtask

  initial begin
    {rst_n, hold_reset, slave_mode, sync_clock_pair, frame_tick, latch_mode} = 6'b010000;
    {heat_warning, heat_shutdown, low_supply_guard, short_to_gnd, short_to_rail} = 5'b00010;
    out_mode = MODE_BRIDGED;
    sense = '0;
    sync_hold = 1'b0;
    wait_cyc(6);
    rst_n = 1'b1;
    t_startup();
    t_clip_sync();
    t_supply_heat();
    t_overcurrent();
    t_dc();
    t_single();
    conclude();
  end
endmodule // testbench
